// ==== logic/mcd_map.svh ====
// Named offsets, field positions, reset values and timing figures of the core.
// Assumes inclusion by bare name from the package and the core.
`ifndef MCD_MAP_SVH
`define MCD_MAP_SVH
`define MCD_IW           12
`define MCD_NFILE        32
`define MCD_ADR_STATUS   5'h03
`define MCD_ADR_PORT     5'h06
`define MCD_OP_DIR       3'h6
`define MCD_ST_C         0
`define MCD_ST_Z         2
`define MCD_CFG_PROT     3
`define MCD_CFG_WDOG     2
`define MCD_CFG_OSC_HI   1
`define MCD_CFG_OSC_LO   0
`define MCD_CFG_IMPL     12'h00f
`define MCD_CFG_RST      12'h000
`define MCD_DRV_RST      8'h00
`define MCD_REG_CFG      8'h00
`define MCD_REG_CTRL     8'h04
`define MCD_REG_WREG     8'h08
`define MCD_REG_PC       8'h0c
`define MCD_REG_PORT     8'h10
`define MCD_REG_INSTR    8'h14
`define MCD_CTRL_RUN     0
`define MCD_CLK_MHZ      40
`define MCD_WDT_TIME_US  18000
`endif

// ==== logic/mcd_pkg.sv ====
// Types shared by the decode core and its field decoder.
// Assumes mcd_map.svh is on the include path.
`include "mcd_map.svh"
package mcd_pkg;
  typedef enum logic [1:0] {
    MCD_CLS_BYTE = 2'b00,
    MCD_CLS_BIT  = 2'b01,
    MCD_CLS_LIT  = 2'b10,
    MCD_CLS_CTL  = 2'b11
  } mcd_cls_e;
  typedef enum logic [1:0] {
    MCD_PH_Q1 = 2'b00,
    MCD_PH_Q2 = 2'b01,
    MCD_PH_Q3 = 2'b10,
    MCD_PH_Q4 = 2'b11
  } mcd_phase_e;
  typedef enum logic [1:0] {
    MCD_LOW_POWER_CRYSTAL_MODE  = 2'b00,
    MCD_STANDARD_CRYSTAL_MODE   = 2'b01,
    MCD_HIGH_SPEED_CRYSTAL_MODE = 2'b10,
    MCD_RESISTOR_CAPACITOR_MODE = 2'b11
  } mcd_osc_e;
  typedef struct packed {
    mcd_cls_e   cls;
    logic [3:0] op;
    logic [4:0] fadr;
    logic       dest;
    logic [2:0] bitn;
    logic [7:0] k8;
    logic [8:0] k9;
    logic       special;
    logic [2:0] sop;
  } mcd_dec_s;
  typedef struct packed {
    logic     code_protect_bit;
    logic     watchdog_enable_bit;
    mcd_osc_e oscillator_select_field;
  } mcd_cfg_s;
endpackage

// ==== logic/mcd_field_decode.sv ====
// Splits a 12-bit instruction word into its class, operation and operand fields.
// Assumes the word is stable for the whole instruction cycle.
`timescale 1ns/100ps
`include "mcd_map.svh"
module mcd_field_decode
  import mcd_pkg::*;
(
  // Instruction word in.
  input  wire logic [`MCD_IW-1:0] instr,
  // Decoded fields out.
  output mcd_dec_s                dec
);
  assign dec.cls     = mcd_cls_e'(instr[11:10]);
  assign dec.op      = instr[9:6];
  assign dec.fadr    = instr[4:0];
  assign dec.dest    = instr[5];
  assign dec.bitn    = instr[7:5];
  assign dec.k8      = instr[7:0];
  assign dec.k9      = instr[8:0];
  // Bits 4 and 3 of the short control words are ignored.
  assign dec.special = (instr[11:5] == 7'h00);
  assign dec.sop     = instr[2:0];
endmodule

// ==== logic/mcd_core.sv ====
// Instruction decode and execution core with one read-modify-write I/O port.
// Assumes a program source answering prog_addr in the same cycle and a strap word.
//
// Chosen here: strobed register access and the placing of the registers.
`timescale 1ns/100ps
`include "mcd_map.svh"
module mcd_core
  import mcd_pkg::*;
#(
  parameter int PC_W       = 9,
  parameter int WDT_CYCLES = `MCD_WDT_TIME_US * `MCD_CLK_MHZ
) (
  // Clock and reset.
  input  wire logic            sys_clk,
  input  wire logic            rst,
  // Register port.
  input  wire logic [7:0]      reg_addr,
  input  wire logic [31:0]     reg_wdata,
  input  wire logic            reg_wr,
  input  wire logic            reg_rd,
  output logic      [31:0]     reg_rdata,
  // Program memory.
  output logic      [PC_W-1:0] prog_addr,
  input  wire logic [11:0]     prog_data,
  // Configuration strap.
  input  wire logic [11:0]     cfg_strap,
  // Port pins.
  input  wire logic [7:0]      port_in,
  output logic      [7:0]      port_out,
  output logic      [7:0]      port_oe,
  // Status.
  output logic                 insn_done,
  output logic                 wdt_timeout,
  output logic                 code_protected,
  output logic      [1:0]      osc_mode
);
  localparam int              WDT_W   = $clog2(WDT_CYCLES + 1);
  localparam logic [PC_W-1:0] RST_VEC = '1;
  localparam logic [PC_W-1:0] PC_ONE  = PC_W'(1);
  localparam logic [PC_W-1:0] PC_TWO  = PC_W'(2);
  localparam logic [WDT_W-1:0] WDT_LAST = WDT_W'(WDT_CYCLES - 1);

  mcd_phase_e       phase;
  mcd_phase_e       next_phase;
  mcd_dec_s         dec;
  mcd_cfg_s         cfg;
  logic [11:0]      cfg_word;
  logic             cfg_valid;
  logic             ctrl_run;
  logic             sleeping;
  logic             flush;
  logic             bubble;
  logic [11:0]      ir;
  logic [7:0]       w;
  logic [7:0]       pin_smp;
  logic [7:0]       port_lat;
  logic [7:0]       port_drv;
  logic             flag_c;
  logic             flag_z;
  logic [PC_W-1:0]  pc;
  logic [PC_W-1:0]  stk0;
  logic [PC_W-1:0]  stk1;
  logic [7:0]       ram [0:`MCD_NFILE-1];
  logic [WDT_W-1:0] wdt_cnt;
  logic [7:0]       res;
  logic [8:0]       sum;
  logic             wr_w;
  logic             wr_f;
  logic             upd_c;
  logic             upd_z;
  logic             new_c;
  logic             skip;
  logic             jump;
  logic [PC_W-1:0]  target;
  logic             push;
  logic             pop;
  logic             set_dir;
  logic             clr_wdt;
  logic             go_sleep;
  logic [31:0]      rd_mux;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    return a == off;
  endfunction

  mcd_field_decode u_dec (
    .instr (ir),
    .dec   (dec)
  );

  wire       run       = ctrl_run & cfg_valid & ~sleeping;
  wire       cyc_start = run & (phase == MCD_PH_Q1);
  wire       cyc_end   = run & (phase == MCD_PH_Q4);
  wire       exec      = ~bubble;
  wire       taken     = skip | jump;
  wire       commit    = cyc_end & exec;
  wire       wdt_fire  = cfg.watchdog_enable_bit & (wdt_cnt == WDT_LAST);
  wire       is_port   = (dec.fadr == `MCD_ADR_PORT);
  wire       is_stat   = (dec.fadr == `MCD_ADR_STATUS);
  wire [7:0] status    = 8'(({7'h00, flag_c} << `MCD_ST_C) | ({7'h00, flag_z} << `MCD_ST_Z));
  // Port file reads the sampled pins, so input bits fold into the latch.
  wire [7:0] fval      = is_port ? pin_smp : is_stat ? status : ram[dec.fadr];
  wire [7:0] bmask     = 8'(8'h01 << dec.bitn);
  wire       new_z     = (res == 8'h00);
  wire       wr_ctrl   = reg_wr & hit(reg_addr, `MCD_REG_CTRL);

  // The configuration word is captured once after reset and then held.
  assign cfg.code_protect_bit        = cfg_word[`MCD_CFG_PROT];
  assign cfg.watchdog_enable_bit     = cfg_word[`MCD_CFG_WDOG];
  assign cfg.oscillator_select_field =
    mcd_osc_e'(cfg_word[`MCD_CFG_OSC_HI:`MCD_CFG_OSC_LO]);
  assign osc_mode       = cfg.oscillator_select_field;
  assign code_protected = ~cfg.code_protect_bit;
  assign prog_addr      = pc;
  assign port_out       = port_lat;
  // Only pins the core drives are enabled; inputs float for the outside.
  assign port_oe        = port_drv;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cfg_word  <= `MCD_CFG_RST;
      cfg_valid <= 1'b0;
    end else if (!cfg_valid) begin
      cfg_word  <= cfg_strap & `MCD_CFG_IMPL;
      cfg_valid <= 1'b1;
    end
  end

  always_comb begin
    case (phase)
      MCD_PH_Q1: next_phase = MCD_PH_Q2;
      MCD_PH_Q2: next_phase = MCD_PH_Q3;
      MCD_PH_Q3: next_phase = MCD_PH_Q4;
      MCD_PH_Q4: next_phase = MCD_PH_Q1;
      default:   next_phase = MCD_PH_Q1;
    endcase
  end

  always_comb begin
    res      = 8'h00;
    sum      = 9'h000;
    wr_w     = 1'b0;
    wr_f     = 1'b0;
    upd_c    = 1'b0;
    upd_z    = 1'b0;
    new_c    = flag_c;
    skip     = 1'b0;
    jump     = 1'b0;
    target   = pc;
    push     = 1'b0;
    pop      = 1'b0;
    set_dir  = 1'b0;
    clr_wdt  = 1'b0;
    go_sleep = 1'b0;
    case (dec.cls)
      MCD_CLS_BYTE: begin
        wr_w  = ~dec.dest;
        wr_f  = dec.dest;
        upd_z = 1'b1;
        case (dec.op)
          4'h0: begin
            res   = w;
            upd_z = 1'b0;
            wr_w  = 1'b0;
            if (!dec.dest && dec.special) begin
              go_sleep = (dec.sop == 3'h3);
              clr_wdt  = (dec.sop == 3'h4);
              set_dir  = (dec.sop == `MCD_OP_DIR);
            end
          end
          4'h1: res = 8'h00;
          4'h2: begin
            sum   = {1'b0, fval} + {1'b0, ~w} + 9'h001;
            res   = sum[7:0];
            new_c = sum[8];
            upd_c = 1'b1;
          end
          4'h3: res = fval - 8'h01;
          4'h4: res = fval | w;
          4'h5: res = fval & w;
          4'h6: res = fval ^ w;
          4'h7: begin
            sum   = {1'b0, fval} + {1'b0, w};
            res   = sum[7:0];
            new_c = sum[8];
            upd_c = 1'b1;
          end
          4'h8: res = fval;
          4'h9: res = ~fval;
          4'ha: res = fval + 8'h01;
          4'hb: begin
            res   = fval - 8'h01;
            upd_z = 1'b0;
            skip  = (res == 8'h00);
          end
          4'hc: begin
            res   = {flag_c, fval[7:1]};
            new_c = fval[0];
            upd_c = 1'b1;
            upd_z = 1'b0;
          end
          4'hd: begin
            res   = {fval[6:0], flag_c};
            new_c = fval[7];
            upd_c = 1'b1;
            upd_z = 1'b0;
          end
          4'he: begin
            res   = {fval[3:0], fval[7:4]};
            upd_z = 1'b0;
          end
          default: begin
            res   = fval + 8'h01;
            upd_z = 1'b0;
            skip  = (res == 8'h00);
          end
        endcase
      end
      MCD_CLS_BIT: begin
        // Set and clear rewrite the whole byte read from the file.
        res  = dec.op[2] ? (fval | bmask) : (fval & ~bmask);
        wr_f = ~dec.op[3];
        skip = dec.op[3] & (dec.op[2] == ((fval & bmask) != 8'h00));
      end
      MCD_CLS_LIT: begin
        jump = 1'b1;
        case (dec.op[3:2])
          2'b00: begin
            res    = dec.k8;
            wr_w   = 1'b1;
            target = stk0;
            pop    = 1'b1;
          end
          2'b01: begin
            target = PC_W'(dec.k8);
            push   = 1'b1;
          end
          default: target = PC_W'(dec.k9);
        endcase
      end
      default: begin
        wr_w  = 1'b1;
        upd_z = (dec.op[3:2] != 2'b00);
        case (dec.op[3:2])
          2'b00:   res = dec.k8;
          2'b01:   res = dec.k8 | w;
          2'b10:   res = dec.k8 & w;
          default: res = dec.k8 ^ w;
        endcase
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (rst || wdt_fire) begin
      phase    <= MCD_PH_Q1;
      ir       <= 12'h000;
      pin_smp  <= 8'h00;
      bubble   <= 1'b0;
      flush    <= 1'b0;
      sleeping <= 1'b0;
      w        <= 8'h00;
      flag_c   <= 1'b0;
      flag_z   <= 1'b0;
      pc       <= RST_VEC;
      stk0     <= RST_VEC;
      stk1     <= RST_VEC;
      port_lat <= 8'h00;
      port_drv <= `MCD_DRV_RST;
    end else begin
      if (run) begin
        phase <= next_phase;
      end
      if (cyc_start) begin
        ir      <= prog_data;
        // Pins are taken at the start; a read right after a write sees the new latch on driven pins.
        pin_smp <= port_in;
        bubble  <= flush;
        flush   <= 1'b0;
      end
      if (cyc_end) begin
        flush <= exec & taken;
      end
      if (commit) begin
        if (wr_w) begin
          w <= res;
        end
        if (wr_f && is_port) begin
          port_lat <= res;
        end
        if (wr_f && is_stat) begin
          flag_c <= res[`MCD_ST_C];
          flag_z <= res[`MCD_ST_Z];
        end
        if (upd_c) begin
          flag_c <= new_c;
        end
        if (upd_z) begin
          flag_z <= new_z;
        end
        if (set_dir) begin
          port_drv <= ~w;
        end
        if (go_sleep) begin
          sleeping <= 1'b1;
        end
        if (push) begin
          stk0 <= pc + PC_ONE;
          stk1 <= stk0;
        end
        if (pop) begin
          stk0 <= stk1;
        end
        pc <= jump ? target : skip ? pc + PC_TWO : pc + PC_ONE;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (commit && wr_f && !is_port && !is_stat) begin
      ram[dec.fadr] <= res;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst || wdt_fire || !cfg.watchdog_enable_bit || (commit && (clr_wdt || go_sleep))) begin
      wdt_cnt <= '0;
    end else begin
      wdt_cnt <= wdt_cnt + WDT_W'(1);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ctrl_run    <= 1'b0;
      reg_rdata   <= 32'h0;
      insn_done   <= 1'b0;
      wdt_timeout <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        ctrl_run <= reg_wdata[`MCD_CTRL_RUN];
      end
      reg_rdata   <= reg_rd ? rd_mux : 32'h0;
      insn_done   <= commit & ~wdt_fire;
      wdt_timeout <= wdt_fire;
    end
  end

  assign rd_mux = hit(reg_addr, `MCD_REG_CFG)  ? {20'h0, cfg_word} :
                  hit(reg_addr, `MCD_REG_CTRL) ? {29'h0, cfg_valid, sleeping, ctrl_run} :
                  hit(reg_addr, `MCD_REG_WREG) ? {16'h0, status, w} :
                  hit(reg_addr, `MCD_REG_PC)   ? 32'(pc) :
                  hit(reg_addr, `MCD_REG_PORT) ? {8'h0, pin_smp, port_drv, port_lat} :
                  (hit(reg_addr, `MCD_REG_INSTR) && cfg.code_protect_bit) ? {20'h0, ir} :
                  32'h0;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  AST_CYCLE_FOUR: assert property (
    (cyc_start && !wdt_fire) ##1 (run && !wdt_fire) [*3] |-> cyc_end)
    else $error("Instruction cycle is not four clocks.");
  AST_PORT_AT_END: assert property (
    !$stable(port_lat) |-> $past(cyc_end || wdt_fire || rst))
    else $error("Port latch changed outside a cycle end.");
  AST_PIN_AT_START: assert property (
    !$stable(pin_smp) |-> $past(cyc_start || wdt_fire || rst))
    else $error("Pin sample changed outside a cycle start.");
  AST_RMW_PORT: assert property (
    (commit && !wdt_fire && dec.cls == MCD_CLS_BIT && !dec.op[3] && is_port)
    |=> port_lat == ($past(dec.op[2]) ? ($past(pin_smp) | $past(bmask))
                                       : ($past(pin_smp) & ~$past(bmask))))
    else $error("Bit operation did not rewrite the sampled port byte.");
  AST_DEST_FILE: assert property (
    (commit && !wdt_fire && dec.cls == MCD_CLS_BYTE && dec.dest) |=> $stable(w))
    else $error("File destination changed the accumulator.");
  AST_DEST_W: assert property (
    (commit && !wdt_fire && dec.cls == MCD_CLS_BYTE && !dec.dest && is_port)
    |=> $stable(port_lat))
    else $error("Accumulator destination changed the port latch.");
  AST_TWO_CYCLE: assert property (
    disable iff (rst || wdt_fire)
    (commit && taken && !wdt_fire) |=> flush ##[1:8] (bubble && cyc_end))
    else $error("Taken skip or jump did not insert an idle cycle.");
  AST_ONE_CYCLE: assert property (
    (cyc_end && !(exec && taken) && !wdt_fire) |=> !flush)
    else $error("Plain instruction took a second cycle.");
  AST_CFG_STATIC: assert property (
    cfg_valid |=> $stable(cfg_word) && ((cfg_word & ~`MCD_CFG_IMPL) == 12'h000))
    else $error("Configuration word moved or shows upper bits.");
  AST_CP_HIDE: assert property (
    (reg_rd && hit(reg_addr, `MCD_REG_INSTR) && !cfg.code_protect_bit) |=> reg_rdata == 32'h0)
    else $error("Protected instruction word was readable.");
  AST_WDT_QUIET: assert property (
    !cfg.watchdog_enable_bit |=> wdt_cnt == '0 && !wdt_timeout)
    else $error("Disabled watchdog is counting.");

  COV_SKIP: cover property (commit && skip);
  COV_PORT_RMW: cover property (commit && dec.cls == MCD_CLS_BIT && is_port);
  COV_CALL: cover property (commit && push);
  COV_WDT: cover property (wdt_fire);
endmodule

// ==== testbench/mcd_pins.sv ====
// Pin model for the port: outside drivers and pull-ups around the core's pins.
// Assumes per-bit drive enables from the core, high while the core drives a pin.
`timescale 1ns/100ps
module mcd_pins
  import mcd_pkg::*;
(
  // Core side.
  input  wire logic [7:0] port_out,
  input  wire logic [7:0] port_oe,
  // Outside drivers.
  input  wire logic [7:0] ext_val,
  input  wire logic [7:0] ext_drv,
  // Pin levels back to the core.
  output logic      [7:0] port_in
);
  logic [7:0] ext_lvl;

  // Outside drivers back off where the core drives, and idle pins float high on pull-ups.
  assign ext_lvl = (ext_drv & ext_val) | ~ext_drv;
  assign port_in = (port_oe & port_out) | (~port_oe & ext_lvl);
endmodule

// ==== testbench/tb.sv ====
// Self-checking bench for the decode core: configuration, port read-modify-write, timing.
// Assumes program memory modelled here and the pin model beside the core.
`timescale 1ns/100ps
`define CHK(nm, ex, gt) begin n_tests++; if ((gt) !== (ex)) begin error_cnt++; \
  $display("wrong value %s expected %h seen %h", nm, ex, gt); end end
module tb
  import mcd_pkg::*;
;
  logic        sys_clk;
  logic        rst;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [31:0] reg_rdata;
  logic [8:0]  prog_addr;
  logic [11:0] prog_data;
  logic [11:0] cfg_strap;
  logic [7:0]  port_in;
  logic [7:0]  port_out;
  logic [7:0]  port_oe;
  logic        insn_done;
  logic        wdt_timeout;
  logic        code_protected;
  logic [1:0]  osc_mode;
  logic [7:0]  ext_val;
  logic [7:0]  ext_drv;
  logic [11:0] mem [512];
  logic [31:0] seed;
  logic [31:0] r;
  logic [31:0] rdv;
  logic [7:0]  e;
  logic [7:0]  k;
  logic [7:0]  k2;
  logic [4:0]  f;
  logic [7:0]  oe_hit;
  logic [7:0]  pprev;
  logic [7:0]  dout [16];
  logic [7:0]  dprev [16];
  logic        hit;
  int          dt [16];
  int          nd;
  int          cyc;
  int          error_cnt;
  int          n_tests;

  mcd_core #(.PC_W(9), .WDT_CYCLES(64)) u_mcd_core (
    .sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .prog_addr(prog_addr),
    .prog_data(prog_data), .cfg_strap(cfg_strap), .port_in(port_in), .port_out(port_out),
    .port_oe(port_oe), .insn_done(insn_done), .wdt_timeout(wdt_timeout),
    .code_protected(code_protected), .osc_mode(osc_mode)
  );
  mcd_pins u_mcd_pins (
    .port_out(port_out), .port_oe(port_oe), .ext_val(ext_val), .ext_drv(ext_drv),
    .port_in(port_in)
  );

  assign prog_data = mem[prog_addr];

  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  // Log the cycle and the port latch around each of the first 16 finished instructions.
  always @(posedge sys_clk) begin
    cyc++;
    if (insn_done === 1'b1 && nd < 16) begin
      dt[nd] = cyc;
      dout[nd] = port_out;
      dprev[nd] = pprev;
      nd++;
    end
    pprev = port_out;
  end

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // Pin level of undriven port bits: outside value where driven, pull-up elsewhere.
  function automatic logic [7:0] ext_pins(input logic [7:0] drv, input logic [7:0] val);
    return (drv & val) | ~drv;
  endfunction

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge sys_clk);
    reg_wr    <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge sys_clk);
    reg_rd   <= 1'b0;
    #1 rdv = reg_rdata;
  endtask

  // Reset with a given strap, then fill memory with no-ops carrying junk in ignored bits.
  task automatic do_reset(input logic [11:0] s);
    @(posedge sys_clk);
    rst       <= 1'b1;
    cfg_strap <= s;
    repeat (8) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    nd = 0;
    for (int a = 0; a < 512; a++) mem[a] = {7'h00, r[4:3], 3'h0};
  endtask

  task automatic wait_done(input int n);
    for (int i = 0; i < 500 && nd < n; i++) @(posedge sys_clk);
    `CHK("done count", 1'b1, nd >= n)
  endtask

  task automatic conclude();
    $display("checks %0d errors %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  initial begin
    #2000000;
    error_cnt++;
    $display("run did not finish in time");
    conclude();
  end

  initial begin
    seed = 32'd81;
    r = 32'h0;
    nd = 0;
    rst = 1'b1;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    cfg_strap = 12'h000;
    ext_val = 8'h00;
    ext_drv = 8'h00;
    // Every oscillator mode and both protect values, with junk in unused strap bits.
    for (int i = 0; i < 4; i++) begin
      r = xs();
      do_reset({r[7:0], i[0], 1'b0, i[1:0]});
      wr(8'h00, r);
      rd(8'h00);
      `CHK("config word", {28'h0, i[0], 1'b0, i[1:0]}, rdv)
      `CHK("osc mode", i[1:0], osc_mode)
      `CHK("protect", ~i[0], code_protected)
      rd(8'h14);
      if (!i[0]) `CHK("hidden instr", 32'h0, rdv)
      rd(8'h20);
      `CHK("unmapped", 32'h0, rdv)
    end
    // Port read-modify-write with pull-ups on the two top pins.
    r = xs();
    @(posedge sys_clk);
    ext_drv <= {2'b00, r[13:12], 4'h0};
    ext_val <= r[23:16];
    do_reset(12'h00d);
    e = 8'hf0 & ext_pins(ext_drv, ext_val);
    mem[0] = 12'hcf0;
    mem[1] = 12'h006;
    mem[2] = 12'h506;
    mem[3] = 12'h4e6;
    mem[4] = 12'h000;
    mem[5] = 12'h206;
    mem[6] = 12'h706;
    mem[7] = 12'hc00;
    mem[8] = 12'ha08;
    wr(8'h04, 32'h1);
    wait_done(10);
    for (int i = 1; i < 10; i++) `CHK("cycle gap", (i >= 8) ? 8 : 4, dt[i] - dt[i-1])
    `CHK("latch before set", 8'h00, dprev[3])
    `CHK("bit set", e | 8'h01, dout[3])
    `CHK("latch before clear", e | 8'h01, dprev[4])
    `CHK("bit clear", (e | 8'h01) & 8'h7f, dout[4])
    `CHK("direction", 8'h0f, port_oe)
    rd(8'h08);
    `CHK("port read", e | 8'h01, rdv[7:0])
    `CHK("osc static", 2'b01, osc_mode)
    // Literal, file and destination paths; the last pass ends on a zero result.
    for (int i = 0; i < 4; i++) begin
      r = xs();
      k = r[7:0];
      k2 = (i == 3) ? k + 8'h02 : r[23:16];
      f = (i == 3) ? 5'h1f : 5'(8 + r[12:8] % 24);
      do_reset(12'h00d);
      mem[0] = {4'hc, k};
      mem[1] = {7'h01, f};
      mem[2] = {7'h15, f};
      mem[3] = {7'h14, f};
      mem[4] = {4'hf, k2};
      mem[5] = 12'ha05;
      wr(8'h04, 32'h1);
      wait_done(7);
      rd(8'h08);
      `CHK("accumulator", (k + 8'h02) ^ k2, rdv[7:0])
      `CHK("zero flag", ((k + 8'h02) ^ k2) == 8'h00, rdv[10])
      `CHK("jump target", 9'h005, prog_addr)
    end
    // Watchdog: enabled and starved, enabled and fed, disabled.
    for (int i = 0; i < 3; i++) begin
      r = xs();
      do_reset({8'h00, 1'b1, i != 2, 2'b10});
      mem[0] = 12'hc00;
      mem[1] = 12'h006;
      mem[2] = (i == 1) ? 12'h004 : (i == 2) ? 12'h003 : 12'h000;
      mem[3] = 12'ha02;
      wr(8'h04, 32'h1);
      wait_done(3);
      `CHK("all driven", 8'hff, port_oe)
      hit = 1'b0;
      for (int c = 0; c < 300 && !hit; c++) begin
        @(posedge sys_clk);
        #1 if (wdt_timeout === 1'b1) begin
          hit = 1'b1;
          oe_hit = port_oe;
        end
      end
      `CHK("watchdog fired", i == 0, hit)
      if (hit) `CHK("released on expiry", 8'h00, oe_hit)
      if (i == 2) begin
        rd(8'h04);
        `CHK("asleep", 32'h7, rdv)
      end
    end
    conclude();
  end
endmodule
